/* File: hw/cem_monitor.sv */
// Summary of operation
// RULE1: Checking starts alone once enabled, configured, initialised and in user mode.
// RULE2: Error flag rises only after the location search and message register update.
// RULE3: After each report the flag stays low at least 32 checker clocks.
// RULE4: A later bad frame raises the flag again after the message is overwritten.
// RULE5: Reader may unload the report on each rising edge of the flag.
// RULE6: Once started, frames are checked in a loop until reset.
// RULE7: Checker clock is the 100 MHz oscillator divided by 2^n, n from 1 to 8.
// RULE8: A CRC is computed and checked per frame, not over the whole image.
// RULE9: Every error overwrites the message register, read or not.
// RULE10: Reader must shift out the report within one frame check period.
// RULE11: Message register updates are spaced by at least one frame check interval.
// RULE12: A full pass over all frames takes a long minimum time per clock setting.
// RULE13: System recovers by pulsing the configuration restart input low.
// RULE14: When enabled, the flag also drives the optional dual-purpose output pin.
// RULE15: Message register is 46 bits: type, location and syndrome, shifted out.
// RULE16: Update register loads one cycle after validation, guarded while sampled.
// RULE17: Error flag derives from the syndrome of the frame being verified.
// RULE18: Divide exponent is static from configuration while checking runs.
module cem_monitor
  import cem_pkg::*;
#(
  parameter int unsigned FRAME_WORDS = 32,
  parameter int unsigned NUM_FRAMES  = 32
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // Configuration status
  input  wire logic                  feature_en,
  input  wire logic                  config_done,
  input  wire logic                  init_done,
  input  wire logic                  user_mode,
  input  wire logic [3:0]            div_exp,
  // Configuration memory loading
  input  wire logic                  cfg_wr_en,
  input  wire logic [ADDR_WIDTH-1:0] cfg_wr_addr,
  input  wire logic [WORD_WIDTH-1:0] cfg_wr_data,
  input  wire logic [CRC_WIDTH-1:0]  frame_crc_ref,
  output cem_mem_req_t               frame_crc_req,
  // Report readout
  input  wire logic                  user_sample_en,
  output logic [EMR_WIDTH-1:0]       user_update_reg,
  output logic [EMR_WIDTH-1:0]       error_message_reg,
  // Error flag
  output logic                       crc_error,
  output logic                       crc_error_pin,
  output logic                       crc_error_pin_oe
);

  localparam int unsigned MEM_DEPTH = FRAME_WORDS * NUM_FRAMES;

  cem_state_reg_t        r;
  cem_state_reg_t        next_r;
  cem_mem_req_t          rd_req;
  logic [WORD_WIDTH-1:0] rd_data;
  logic [CRC_WIDTH-1:0]  crc_step;
  logic [CRC_WIDTH-1:0]  next_syn;
  logic [$clog2(CRC_WIDTH+1)-1:0] syn_bits;
  logic [ADDR_WIDTH-1:0] frame_after;

  cem_frame_mem #(
    .DEPTH   (MEM_DEPTH)
  ) u_mem (
    .ref_clk (ref_clk),
    .wr_en   (cfg_wr_en),
    .wr_addr (cfg_wr_addr),
    .wr_data (cfg_wr_data),
    .rd_req  (rd_req),
    .rd_data (rd_data)
  );

  // Serial CRC over one word, MSB first
  logic [CRC_WIDTH-1:0] crc_chain [WORD_WIDTH+1];
  assign crc_chain[0] = r.crc;
  for (genvar g = 0; g < WORD_WIDTH; g++) begin : g_crc_bit
    assign crc_chain[g+1] = {crc_chain[g][CRC_WIDTH-2:0], 1'b0} ^
                            ((crc_chain[g][CRC_WIDTH-1] ^ rd_data[WORD_WIDTH-1-g]) ? CRC_POLY : '0);
  end
  assign crc_step = crc_chain[WORD_WIDTH];

  // Syndrome weight of the frame under search
  logic [$clog2(CRC_WIDTH+1)-1:0] syn_count [CRC_WIDTH+1];
  assign next_syn = r.crc ^ frame_crc_ref; // RULE17
  assign syn_count[0] = '0;
  for (genvar g = 0; g < CRC_WIDTH; g++) begin : g_syn_bit
    assign syn_count[g+1] = syn_count[g] + {{($bits(syn_bits)-1){1'b0}}, r.syndrome[g]};
  end
  assign syn_bits = syn_count[CRC_WIDTH];

  // Next frame in the endless loop
  always_comb begin
    if (r.frame == ADDR_WIDTH'(NUM_FRAMES - 1)) begin // RULE6 RULE12
      frame_after = '0;
    end else begin
      frame_after = r.frame + 1'b1;
    end
  end

  always_comb begin
    next_r = r;
    rd_req = '0;
    frame_crc_req = '0;
    next_r.tick = 1'b0;
    next_r.emr_valid_d = 1'b0;

    // Divided checker clock enable
    if (r.running) begin
      next_r.div_cnt = r.div_cnt + 8'h01;
      if (r.div_cnt == ((8'h01 << r.div_exp) - 8'h01)) begin // RULE7
        next_r.div_cnt = '0;
        next_r.tick = 1'b1;
      end
    end

    case (r.state)
      CEM_IDLE: begin
        if (feature_en && config_done && init_done && user_mode) begin // RULE1
          next_r.running = 1'b1;
          // Exponent latched once, held for the whole run
          if (div_exp < 4'(DIV_EXP_MIN)) begin // RULE18
            next_r.div_exp = 4'(DIV_EXP_MIN);
          end else if (div_exp > 4'(DIV_EXP_MAX)) begin
            next_r.div_exp = 4'(DIV_EXP_MAX);
          end else begin
            next_r.div_exp = div_exp;
          end
          next_r.frame = '0;
          next_r.word = '0;
          next_r.crc = CRC_INIT;
          next_r.state = CEM_READ;
        end
      end
      CEM_READ: begin
        if (r.tick && !r.rd_pending) begin
          rd_req.en = 1'b1;
          rd_req.addr = ADDR_WIDTH'(r.frame * FRAME_WORDS + r.word);
          next_r.rd_pending = 1'b1;
        end else if (r.rd_pending) begin
          next_r.rd_pending = 1'b0;
          next_r.crc = crc_step; // RULE8
          if (r.word == ADDR_WIDTH'(FRAME_WORDS - 1)) begin
            next_r.state = CEM_CHECK;
            frame_crc_req.en = 1'b1;
            frame_crc_req.addr = r.frame;
          end else begin
            next_r.word = r.word + 1'b1;
          end
        end
      end
      CEM_CHECK: begin
        next_r.syndrome = next_syn;
        next_r.bit_idx = '0;
        if (next_syn != '0) begin
          next_r.state = CEM_SEARCH;
        end else begin
          next_r.state = CEM_READ;
        end
        next_r.word = '0;
        next_r.crc = CRC_INIT;
        next_r.frame = frame_after; // RULE6
        if (next_syn != '0) begin
          next_r.frame = r.frame;
        end
      end
      CEM_SEARCH: begin
        // Location search: first set syndrome bit
        if (r.tick) begin
          if (r.syndrome[r.bit_idx[4:0]] || r.bit_idx == 6'(CRC_WIDTH - 1)) begin
            next_r.error_message_reg.syndrome = r.syndrome; // RULE9 RULE15
            next_r.error_message_reg.location =
              EMR_LOC_WIDTH'({r.frame[EMR_LOC_WIDTH-6:0], r.bit_idx[4:0]});
            next_r.error_message_reg.err_type =
              (syn_bits == 1) ? ERR_TYPE_SINGLE : ERR_TYPE_MULTI;
            next_r.emr_valid_d = 1'b1;
            next_r.state = CEM_REPORT;
          end else begin
            next_r.bit_idx = r.bit_idx + 6'h01;
          end
        end
      end
      CEM_REPORT: begin
        next_r.crc_error = 1'b1; // RULE2 RULE4
        next_r.quiet_cnt = '0;
        next_r.state = CEM_QUIET;
      end
      CEM_QUIET: begin
        // Hold at least one frame of checker clocks low before next report
        next_r.crc_error = 1'b0;
        if (r.tick) begin
          next_r.quiet_cnt = r.quiet_cnt + 6'h01;
        end
        if (r.quiet_cnt == 6'(FLAG_LOW_CYCLES)) begin // RULE3 RULE11
          next_r.frame = frame_after;
          next_r.state = CEM_READ;
        end
      end
      default: begin
        next_r.state = CEM_IDLE;
      end
    endcase

    // Update register follows one cycle after validation unless sampled
    if (r.emr_valid_d && !user_sample_en) begin // RULE16
      next_r.user_update = r.error_message_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign crc_error = r.crc_error;
  assign crc_error_pin = r.crc_error; // RULE14
  assign crc_error_pin_oe = r.running & feature_en;
  assign error_message_reg = r.error_message_reg;
  assign user_update_reg = r.user_update;

endmodule

/* File: hw/cem_pkg.sv */
package cem_pkg;

  // Oscillator and divider
  localparam int unsigned OSC_FREQ_MHZ    = 100;
  localparam int unsigned DIV_EXP_MIN     = 1;
  localparam int unsigned DIV_EXP_MAX     = 8;
  localparam logic [3:0]  DIV_EXP_RESET   = 4'h1;

  // Reporting
  localparam int unsigned FLAG_LOW_CYCLES = 32;
  localparam int unsigned EMR_WIDTH       = 46;
  localparam int unsigned CRC_WIDTH       = 32;
  localparam int unsigned WORD_WIDTH      = 32;
  localparam int unsigned ADDR_WIDTH      = 16;

  // Error message field layout
  localparam int unsigned EMR_SYN_LSB     = 0;
  localparam int unsigned EMR_LOC_LSB     = 32;
  localparam int unsigned EMR_LOC_WIDTH   = 12;
  localparam int unsigned EMR_TYPE_LSB    = 44;
  localparam int unsigned EMR_TYPE_WIDTH  = 2;

  localparam logic [1:0]  ERR_TYPE_SINGLE = 2'h1;
  localparam logic [1:0]  ERR_TYPE_MULTI  = 2'h3;
  localparam logic [31:0] CRC_POLY        = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT        = 32'hffffffff;

  typedef enum logic [2:0] {
    CEM_IDLE   = 3'h0,
    CEM_READ   = 3'h1,
    CEM_CHECK  = 3'h3,
    CEM_SEARCH = 3'h2,
    CEM_REPORT = 3'h6,
    CEM_QUIET  = 3'h7
  } cem_state_t;

  typedef struct packed {
    logic [EMR_TYPE_WIDTH-1:0] err_type;
    logic [EMR_LOC_WIDTH-1:0]  location;
    logic [CRC_WIDTH-1:0]      syndrome;
  } cem_emr_t;

  typedef struct packed {
    logic                  en;
    logic [ADDR_WIDTH-1:0] addr;
  } cem_mem_req_t;

  typedef struct packed {
    cem_state_t            state;
    logic                  running;
    logic [3:0]            div_exp;
    logic [7:0]            div_cnt;
    logic                  tick;
    logic [ADDR_WIDTH-1:0] frame;
    logic [ADDR_WIDTH-1:0] word;
    logic                  rd_pending;
    logic [CRC_WIDTH-1:0]  crc;
    logic [CRC_WIDTH-1:0]  syndrome;
    logic [5:0]            bit_idx;
    logic [5:0]            quiet_cnt;
    cem_emr_t              error_message_reg;
    logic                  emr_valid_d;
    cem_emr_t              user_update;
    logic                  crc_error;
  } cem_state_reg_t;

endpackage

/* File: hw/cem_frame_mem.sv */
module cem_frame_mem
  import cem_pkg::*;
#(
  parameter int unsigned DEPTH = 1024
) (
  // Clock only, no reset
  input  wire logic                  ref_clk,
  // Write port
  input  wire logic                  wr_en,
  input  wire logic [ADDR_WIDTH-1:0] wr_addr,
  input  wire logic [WORD_WIDTH-1:0] wr_data,
  // Read port
  input  wire cem_mem_req_t          rd_req,
  output logic      [WORD_WIDTH-1:0] rd_data
);

  logic [WORD_WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr[$clog2(DEPTH)-1:0]] <= wr_data;
    end
    if (rd_req.en) begin
      rd_data <= mem[rd_req.addr[$clog2(DEPTH)-1:0]];
    end
  end

endmodule

/* File: tb/cem_monitor_asserts.sv */
module cem_monitor_asserts
  import cem_pkg::*;
#(
  parameter int unsigned FRAME_WORDS = 32,
  parameter int unsigned NUM_FRAMES  = 32
) (
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  // Watched inputs
  input wire logic                 feature_en,
  input wire logic                 config_done,
  input wire logic                 init_done,
  input wire logic                 user_mode,
  input wire logic                 user_sample_en,
  // Watched outputs
  input wire cem_mem_req_t         frame_crc_req,
  input wire logic [EMR_WIDTH-1:0] user_update_reg,
  input wire logic [EMR_WIDTH-1:0] error_message_reg,
  input wire logic                 crc_error,
  input wire logic                 crc_error_pin,
  input wire logic                 crc_error_pin_oe
);
  logic [5:0]  gap;
  logic        started;
  logic [15:0] idle;

  // Low cycles since flag, start seen, cycles without a frame request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap     <= 6'h20;
      started <= 1'b0;
      idle    <= 16'h0;
    end else begin
      gap     <= crc_error ? 6'h0 : ((gap == 6'h3f) ? gap : gap + 6'h1);
      started <= started | (feature_en & config_done & init_done & user_mode);
      idle    <= (frame_crc_req.en || !started) ? 16'h0 : idle + 16'h1;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_flag_next;
    ##1 crc_error ##1 !crc_error;
  endsequence

  property p_pin; crc_error_pin == crc_error; endproperty
  property p_oe; crc_error_pin_oe == (started && feature_en); endproperty
  property p_gap; $rose(crc_error) |-> gap >= 6'h20; endproperty
  property p_syn; crc_error |-> error_message_reg[31:0] != 32'h0; endproperty
  property p_report; $changed(error_message_reg) |-> s_flag_next; endproperty
  property p_load;
    $rose(crc_error) && !user_sample_en && !$past(user_sample_en)
      |-> ##[0:1] (user_update_reg == error_message_reg);
  endproperty
  property p_hold; user_sample_en && $past(user_sample_en) |-> $stable(user_update_reg); endproperty
  property p_idle; !started |-> !frame_crc_req.en; endproperty
  property p_loop; idle < 16'h9c40; endproperty

  a_pin: assert property (p_pin) else $error("flag pin differs from flag");
  a_oe: assert property (p_oe) else $error("pin enable does not follow feature and start");
  a_gap: assert property (p_gap) else $error("flag low gap too short");
  a_syn: assert property (p_syn) else $error("flag with zero syndrome");
  a_report: assert property (p_report) else $error("message update without flag pulse");
  a_load: assert property (p_load) else $error("update register not loaded");
  a_hold: assert property (p_hold) else $error("update register written while sampled");
  a_idle: assert property (p_idle) else $error("checking before start");
  a_loop: assert property (p_loop) else $error("frame checking stalled");
endmodule

bind cem_monitor cem_monitor_asserts #(.FRAME_WORDS(FRAME_WORDS), .NUM_FRAMES(NUM_FRAMES)) cem_monitor_asserts_i (
  .ref_clk, .rst_n, .feature_en, .config_done, .init_done, .user_mode, .user_sample_en, .frame_crc_req,
  .user_update_reg, .error_message_reg, .crc_error, .crc_error_pin, .crc_error_pin_oe);

/* File: tb/cem_supervisor.sv */
module cem_supervisor
  import cem_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // Report side
  input  wire logic                 crc_error,
  input  wire logic [EMR_WIDTH-1:0] user_update_reg,
  input  wire logic [7:0]           hold,
  output logic                      user_sample_en,
  output logic [EMR_WIDTH-1:0]      report
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       grab;
  logic [7:0] cnt;

  // Unload on each flag, shift for hold cycles
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      grab   <= 1'b0;
      cnt    <= 8'h0;
      report <= '0;
    end else begin
      grab <= crc_error;
      if (grab) begin
        report <= user_update_reg;
        cnt    <= hold;
      end else if (cnt != 8'h0) begin
        cnt <= cnt - 8'h1;
      end
    end
  end
  assign user_sample_en = (cnt != 8'h0);
endmodule

/* File: tb/cem_monitor_tb.sv */
module cem_monitor_tb
  import cem_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FW = 2;
  localparam int NF = 2;
  typedef struct {logic [31:0] pat; logic [1:0] typ; logic [11:0] loc;} cem_row_t;
  logic ref_clk, rst_n, feature_en, config_done, init_done, user_mode, cfg_wr_en;
  logic user_sample_en, crc_error, crc_error_pin, crc_error_pin_oe;
  logic [3:0]           div_exp;
  logic [15:0]          cfg_wr_addr;
  logic [31:0]          cfg_wr_data, frame_crc_ref;
  cem_mem_req_t         frame_crc_req;
  logic [EMR_WIDTH-1:0] user_update_reg, error_message_reg, report, first;
  logic [7:0]           hold;
  logic [31:0]          refv [NF];
  int                   errors, checks_done;
  cem_row_t rows [3] = '{'{32'h1, ERR_TYPE_SINGLE, 12'h000}, '{32'h80000000, ERR_TYPE_SINGLE, 12'h01f},
                         '{32'h5, ERR_TYPE_MULTI, 12'h000}};

  cem_monitor #(.FRAME_WORDS(FW), .NUM_FRAMES(NF)) cem_monitor_i (.ref_clk, .rst_n, .feature_en, .config_done,
    .init_done, .user_mode, .div_exp, .cfg_wr_en, .cfg_wr_addr, .cfg_wr_data, .frame_crc_ref, .frame_crc_req,
    .user_sample_en, .user_update_reg, .error_message_reg, .crc_error, .crc_error_pin, .crc_error_pin_oe);
  cem_supervisor cem_supervisor_i (.ref_clk, .rst_n, .crc_error, .user_update_reg, .hold, .user_sample_en, .report);

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (frame_crc_req.en) frame_crc_ref <= #1 refv[frame_crc_req.addr[0]];

  function automatic logic [31:0] crc_of(int f);
    logic [31:0] c;
    logic [31:0] d;
    c = CRC_INIT;
    for (int w = 0; w < FW; w++) begin
      d = 32'ha5a50000 + 32'(f * FW + w);
      for (int i = 31; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? CRC_POLY : 32'h0);
    end
    return c;
  endfunction

  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(string what, logic [EMR_WIDTH-1:0] seen, logic [EMR_WIDTH-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_flag();
    int n;
    n = 0;
    while (crc_error !== 1'b1 && n < 3000) begin
      step(1);
      n++;
    end
    check("flag", 46'(crc_error), 46'h1);
    step(1);
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    stop_test();
  end

  initial begin
    {ref_clk, rst_n, feature_en, config_done, init_done, user_mode, cfg_wr_en} = 7'h0;
    {div_exp, cfg_wr_addr, cfg_wr_data, hold} = {4'h1, 16'h0, 32'h0, 8'h4};
    {errors, checks_done} = 0;
    refv[0] = crc_of(0);
    refv[1] = crc_of(1);
    step(5);
    check("reset flag", 46'(crc_error), 46'h0);
    check("reset message", error_message_reg, 46'h0);
    step(1);
    rst_n = 1'b1;
    {feature_en, config_done, init_done} = 3'h7;
    for (int i = 0; i < NF * FW; i++) begin
      {cfg_wr_en, cfg_wr_addr, cfg_wr_data} = {1'b1, 16'(i), 32'ha5a50000 + 32'(i)};
      step(1);
    end
    cfg_wr_en = 1'b0;
    step(40);
    check("idle pin enable", 46'(crc_error_pin_oe), 46'h0);
    user_mode = 1'b1;
    step(2);
    check("run pin enable", 46'(crc_error_pin_oe), 46'h1);
    foreach (rows[r]) begin
      refv[0] = crc_of(0) ^ rows[r].pat;
      wait_flag();
      wait_flag();
      check("syndrome", 46'(error_message_reg[31:0]), 46'(rows[r].pat));
      check("type", 46'(error_message_reg[45:44]), 46'(rows[r].typ));
      check("location", 46'(error_message_reg[43:32]), 46'(rows[r].loc));
      step(2);
      check("report", 46'(report[31:0]), 46'(rows[r].pat));
    end
    refv[0] = crc_of(0) ^ 32'h1;
    refv[1] = crc_of(1) ^ 32'h2;
    wait_flag();
    wait_flag();
    wait_flag();
    hold = 8'hff;
    step(2);
    first = error_message_reg;
    check("loaded", user_update_reg, first);
    wait_flag();
    check("overwrite", 46'(error_message_reg[31:0]), 46'(first[31:0] ^ 32'h3));
    check("refused", user_update_reg, first);
    hold = 8'h4;
    rst_n = 1'b0;
    step(2);
    check("restart message", error_message_reg, 46'h0);
    rst_n = 1'b1;
    wait_flag();
    stop_test();
  end
endmodule
